// file: verilog/ctu_defs.vh
// Register offsets, field positions, reset values and codes for the charge-time edge control block
`ifndef CTU_DEFS_VH
`define CTU_DEFS_VH

// Register indices; the byte address of each register is its index times four
`define CTU_IDX_CTRL_LOW      12'hFB2
`define CTU_IDX_CTRL_HIGH     12'hFB1
`define CTU_IDX_TRIM          12'hFB3
`define CTU_IDX_STATUS        12'hFB4
`define CTU_ADDR_W            14

// High control fields
`define CTU_H_UNIT_EN         7
`define CTU_H_STOP_IDLE       5
`define CTU_H_DPG_EN          4
`define CTU_H_EDGE_EN         3
`define CTU_H_EDGE_SEQ        2
`define CTU_H_DISCHARGE       1
`define CTU_H_MASK            8'hBE

// Low control fields
`define CTU_L_E2_POL          7
`define CTU_L_E2_SEL_HI       6
`define CTU_L_E2_SEL_LO       5
`define CTU_L_E1_POL          4
`define CTU_L_E1_SEL_HI       3
`define CTU_L_E1_SEL_LO       2
`define CTU_L_E2_FLAG         1
`define CTU_L_E1_FLAG         0

// Source select codes
`define CTU_SEL_PIN_A         2'h3
`define CTU_SEL_PIN_B         2'h2
`define CTU_SEL_CMP_TWO       2'h0

// Reset values
`define CTU_RST_BYTE          8'h00

// AXI responses
`define CTU_RESP_OKAY         2'h0
`define CTU_RESP_SLVERR       2'h2

`endif

// file: verilog/ctu_edge_control.v
// Charge-time unit edge control: edge qualification, flags, current source gate, delay pulse, AXI4-Lite registers
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// - With delay-pulse generation on, the generated pulse drives the dedicated pulse output pin.
// - In delay mode the output pulse comes when comparator 2 reports the capacitor at the trip level.
// - Entering any Sleep mode forces the current source off.
// - In Idle, stop-in-idle (high control bit 5) clear keeps the unit running, set turns the source off.
// - Any reset clears every register except the input synchronizer stages, leaving the unit disabled and the source off.
// - A measurement under way at reset is abandoned with nothing kept.
// - Discharge bit (high control bit 1) connects the discharge path while set.
// - Source select 11 picks pin A, 10 pin B, 00 compare unit two trigger, 01 compare unit one trigger.
// - An edge's selected event sets its flag (edge 2 bit 1, edge 1 bit 0 of low control).
`include "ctu_defs.vh"
module ctu_edge_control
(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address and data
	input  wire [13:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [13:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Edge sources and comparator
	input  wire        edge_input_pin_a,
	input  wire        edge_input_pin_b,
	input  wire        compare_unit_one_trig,
	input  wire        compare_unit_two_trig,
	input  wire        comparator_two_out,
	// Power state
	input  wire        sleep_mode,
	input  wire        idle_mode,
	// Analog controls
	output reg         current_source_en,
	output reg         discharge_en,
	output reg  [7:0]  current_trim,
	output reg         delay_pulse_out
);

	reg  [7:0]  ctrl_high_reg;
	reg  [7:0]  ctrl_low_reg;
	reg  [7:0]  trim_reg;
	reg  [2:0]  pin_a_sync_reg;
	reg  [2:0]  pin_b_sync_reg;
	reg  [2:0]  cmp_sync_reg;
	reg  [2:0]  slp_sync_reg;
	reg  [2:0]  idl_sync_reg;
	reg         pin_a_reg;
	reg         pin_b_reg;
	reg         cmp_reg;
	reg         slp_reg;
	reg         idl_reg;
	reg         src1_prev_reg;
	reg         src2_prev_reg;
	reg         cmp_prev_reg;
	reg         aw_hold_reg;
	reg         w_hold_reg;
	reg  [13:0] aw_addr_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;

	wire        unit_en   = ctrl_high_reg[`CTU_H_UNIT_EN];
	wire        dpg_en    = ctrl_high_reg[`CTU_H_DPG_EN];
	wire        edge_en   = ctrl_high_reg[`CTU_H_EDGE_EN];
	wire        edge_seq  = ctrl_high_reg[`CTU_H_EDGE_SEQ];

	// Source select mux
	function sel_src;
		input [1:0] sel;
		input       a;
		input       b;
		input       c1;
		input       c2;
		begin
			if (sel == `CTU_SEL_PIN_A)
				sel_src = a;
			else if (sel == `CTU_SEL_PIN_B)
				sel_src = b;
			else if (sel == `CTU_SEL_CMP_TWO)
				sel_src = c2;
			else
				sel_src = c1;
		end
	endfunction

	wire        src1 = sel_src(ctrl_low_reg[`CTU_L_E1_SEL_HI:`CTU_L_E1_SEL_LO], pin_a_reg, pin_b_reg,
		compare_unit_one_trig, compare_unit_two_trig);
	wire        src2 = sel_src(ctrl_low_reg[`CTU_L_E2_SEL_HI:`CTU_L_E2_SEL_LO], pin_a_reg, pin_b_reg,
		compare_unit_one_trig, compare_unit_two_trig);
	// Polarity 1 rising, 0 falling
	wire        ev1 = ctrl_low_reg[`CTU_L_E1_POL] ? (src1 & ~src1_prev_reg) : (~src1 & src1_prev_reg);
	wire        ev2 = ctrl_low_reg[`CTU_L_E2_POL] ? (src2 & ~src2_prev_reg) : (~src2 & src2_prev_reg);
	wire        arm = unit_en & edge_en;
	wire        set1 = arm & ev1;
	wire        set2 = arm & ev2 & (~edge_seq | ctrl_low_reg[`CTU_L_E1_FLAG]);
	// Comparator trip: rising comparator output in delay mode
	wire        trip = unit_en & dpg_en & cmp_reg & ~cmp_prev_reg;

	wire        wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	wire [11:0] wr_idx = aw_addr_reg[13:2];
	wire [11:0] rd_idx = s_axi_araddr[13:2];
	wire        wr_low  = wr_go & (wr_idx == `CTU_IDX_CTRL_LOW) & w_strb_reg[0];
	wire        wr_high = wr_go & (wr_idx == `CTU_IDX_CTRL_HIGH) & w_strb_reg[0];
	wire        wr_trim = wr_go & (wr_idx == `CTU_IDX_TRIM) & w_strb_reg[0];
	wire        wr_map  = (wr_idx == `CTU_IDX_CTRL_LOW) | (wr_idx == `CTU_IDX_CTRL_HIGH) |
		(wr_idx == `CTU_IDX_TRIM) | (wr_idx == `CTU_IDX_STATUS);

	reg  [7:0]  low_next;
	reg         src_on_next;

	always @*
	begin
		low_next = ctrl_low_reg;
		if (wr_low)
			low_next = w_data_reg[7:0];
		// Hardware set wins over a software clear
		if (set1)
			low_next[`CTU_L_E1_FLAG] = 1'b1;
		if (set2)
			low_next[`CTU_L_E2_FLAG] = 1'b1;
		// Delay mode: edge 1 charges until comparator trips, then the flag drops
		if (trip)
			low_next[`CTU_L_E1_FLAG] = 1'b0;
		// Source charges while edge 1 seen and edge 2 not yet
		src_on_next = unit_en & low_next[`CTU_L_E1_FLAG] & ~low_next[`CTU_L_E2_FLAG];
		if (slp_reg)
			src_on_next = 1'b0;
		if (idl_reg & ctrl_high_reg[`CTU_H_STOP_IDLE])
			src_on_next = 1'b0;
	end

	always @(posedge aclk)
	begin
		pin_a_sync_reg <= {pin_a_sync_reg[1:0], edge_input_pin_a};
		pin_b_sync_reg <= {pin_b_sync_reg[1:0], edge_input_pin_b};
		cmp_sync_reg   <= {cmp_sync_reg[1:0], comparator_two_out};
		slp_sync_reg   <= {slp_sync_reg[1:0], sleep_mode};
		idl_sync_reg   <= {idl_sync_reg[1:0], idle_mode};
		if (!aresetn)
		begin
			// Every register but the synchronizer stages cleared, any measurement dropped
			ctrl_high_reg     <= `CTU_RST_BYTE;
			ctrl_low_reg      <= `CTU_RST_BYTE;
			trim_reg          <= `CTU_RST_BYTE;
			pin_a_reg         <= 1'b0;
			pin_b_reg         <= 1'b0;
			cmp_reg           <= 1'b0;
			slp_reg           <= 1'b0;
			idl_reg           <= 1'b0;
			src1_prev_reg     <= 1'b0;
			src2_prev_reg     <= 1'b0;
			cmp_prev_reg      <= 1'b0;
			current_source_en <= 1'b0;
			discharge_en      <= 1'b0;
			current_trim      <= `CTU_RST_BYTE;
			delay_pulse_out   <= 1'b0;
			aw_hold_reg       <= 1'b0;
			w_hold_reg        <= 1'b0;
			aw_addr_reg       <= 14'h0000;
			w_data_reg        <= 32'h00000000;
			w_strb_reg        <= 4'h0;
			s_axi_awready     <= 1'b0;
			s_axi_wready      <= 1'b0;
			s_axi_bvalid      <= 1'b0;
			s_axi_bresp       <= `CTU_RESP_OKAY;
			s_axi_arready     <= 1'b0;
			s_axi_rvalid      <= 1'b0;
			s_axi_rresp       <= `CTU_RESP_OKAY;
			s_axi_rdata       <= 32'h00000000;
		end
		else
		begin
			// Accept a change once second and third stages agree
			if (pin_a_sync_reg[1] == pin_a_sync_reg[2])
				pin_a_reg <= pin_a_sync_reg[2];
			if (pin_b_sync_reg[1] == pin_b_sync_reg[2])
				pin_b_reg <= pin_b_sync_reg[2];
			if (cmp_sync_reg[1] == cmp_sync_reg[2])
				cmp_reg <= cmp_sync_reg[2];
			if (slp_sync_reg[1] == slp_sync_reg[2])
				slp_reg <= slp_sync_reg[2];
			if (idl_sync_reg[1] == idl_sync_reg[2])
				idl_reg <= idl_sync_reg[2];
			src1_prev_reg <= src1;
			src2_prev_reg <= src2;
			cmp_prev_reg  <= cmp_reg;

			ctrl_low_reg <= low_next;
			if (wr_high)
				ctrl_high_reg <= w_data_reg[7:0] & `CTU_H_MASK;
			if (wr_trim)
				trim_reg <= w_data_reg[7:0];

			current_source_en <= src_on_next;
			discharge_en      <= ctrl_high_reg[`CTU_H_DISCHARGE];
			current_trim      <= trim_reg;
			// Pulse on the trip, held until edge 1 is armed again
			if (!(unit_en & dpg_en))
				delay_pulse_out <= 1'b0;
			else if (trip)
				delay_pulse_out <= 1'b1;
			else if (low_next[`CTU_L_E1_FLAG])
				delay_pulse_out <= 1'b0;

			// Write channel: address and data in either order
			s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;

			// Read channel
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `CTU_RESP_OKAY;
				if (rd_idx == `CTU_IDX_CTRL_LOW)
					s_axi_rdata <= {24'h000000, ctrl_low_reg};
				else if (rd_idx == `CTU_IDX_CTRL_HIGH)
					s_axi_rdata <= {24'h000000, ctrl_high_reg};
				else if (rd_idx == `CTU_IDX_TRIM)
					s_axi_rdata <= {24'h000000, trim_reg};
				else if (rd_idx == `CTU_IDX_STATUS)
					s_axi_rdata <= {27'h0, delay_pulse_out, cmp_reg, current_source_en, discharge_en,
						idl_reg | slp_reg};
				else
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `CTU_RESP_SLVERR;
				end
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // ctu_edge_control

// file: test/ctu_chk_props.sv
// Port-level assertion checker for the charge-time edge control block
`timescale 1ns/100ps
module ctu_chk
(
	// Clock, reset and bus handshakes
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	// Analog side
	input wire comparator_two_out,
	input wire sleep_mode,
	input wire current_source_en,
	input wire delay_pulse_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_both_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	a_reset_clear: assert property ($rose(aresetn) |-> !current_source_en && !delay_pulse_out)
		else $error("outputs not clear after reset");
	a_trip_first: assert property ($rose(delay_pulse_out) |-> $past(comparator_two_out, 3))
		else $error("pulse without comparator trip");
	a_sleep_off: assert property (sleep_mode [*6] |-> !current_source_en)
		else $error("source on in sleep");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
	a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready too long");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready too long");
	a_b_after: assert property (s_both_taken |-> ##2 s_axi_bvalid) else $error("bvalid late");
	a_r_after: assert property (s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
endmodule // ctu_chk

// file: test/ctu_far_model.sv
// Far-side model: edge source pins, compare triggers and comparator 2
`timescale 1ns/100ps
module ctu_far_model
(
	// Clock
	input wire aclk,
	// Sources seen by the block
	output reg edge_input_pin_a,
	output reg edge_input_pin_b,
	output reg compare_unit_one_trig,
	output reg compare_unit_two_trig,
	output reg comparator_two_out
);
	initial
	begin
		{edge_input_pin_a, edge_input_pin_b} = 2'h0;
		{compare_unit_one_trig, compare_unit_two_trig, comparator_two_out} = 3'h0;
	end
	// Code 4 is the comparator, the others follow the source select codes
	task src(input [2:0] k, input v);
		begin
			@(posedge aclk);
			case (k)
				3'h3: edge_input_pin_a <= v;
				3'h2: edge_input_pin_b <= v;
				3'h1: compare_unit_one_trig <= v;
				3'h0: compare_unit_two_trig <= v;
				default: comparator_two_out <= v;
			endcase
			repeat (8) @(posedge aclk);
		end
	endtask
endmodule // ctu_far_model

// file: test/tb_top.sv
// Self-checking bench for the charge-time edge control block
`timescale 1ns/100ps
module tb_top;
	localparam [13:0] A_HI = 14'h3EC4, A_LO = 14'h3EC8, A_TR = 14'h3ECC;
	reg aclk = 1'b0, aresetn = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
	reg [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
	reg [31:0] s_axi_wdata = 32'h00000000;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, current_source_en, discharge_en;
	wire edge_input_pin_a, edge_input_pin_b, compare_unit_one_trig, compare_unit_two_trig, comparator_two_out;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] current_trim;
	wire delay_pulse_out;
	integer n_fail = 0, comparisons = 0, i;
	reg [31:0] rv, rr;
	reg [2:0] c;
	always #2 aclk = ~aclk;
	ctu_edge_control ctu_edge_control_inst (.*);
	ctu_far_model ctu_far_model_inst (.*);
	task conclude(input bad);
		begin
			n_fail = n_fail + bad;
			$display("comparisons %0d mismatches %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e)
			begin
				n_fail = n_fail + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// One write (w high) or read, then time for the outputs to settle
	task bus(input w, input [13:0] a, input [7:0] d);
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_araddr <= a;
			s_axi_wdata <= {24'h000000, d};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
			{s_axi_arvalid, s_axi_rready} <= {2{!w}};
			for (i = 0; i < 40; i = i + 1)
			begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_bvalid || s_axi_rvalid) i = 99;
			end
			if (i == 40) conclude(1'b1);
			rv = s_axi_rdata;
			rr = {30'h0, w ? s_axi_bresp : s_axi_rresp};
			{s_axi_bready, s_axi_rready} <= 2'h0;
			repeat (8) @(posedge aclk);
		end
	endtask
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (c = 0; c < 4; c = c + 1)
		begin
			bus(1'b0, A_HI + {10'h0, c[1:0], 2'h0}, 8'h00);
			chk("reset", 32'h0, rv);
		end
		bus(1'b0, 14'h0000, 8'h00);
		chk("resp", 32'h2, rr);
		bus(1'b1, A_TR, 8'hA5);
		chk("trim", 32'hA5, {24'h0, current_trim});
		chk("wresp", 32'h0, rr);
		bus(1'b1, 14'h0000, 8'h00);
		chk("wresp_err", 32'h2, rr);
		$display("registers done");
		bus(1'b1, A_HI, 8'h88);
		for (c = 0; c < 4; c = c + 1)
		begin
			bus(1'b1, A_LO, {3'h0, 1'b1, c[1:0], 2'h0});
			ctu_far_model_inst.src(c, 1'b1);
			bus(1'b0, A_LO, 8'h00);
			chk("flag", {27'h0, 1'b1, c[1:0], 2'h1}, rv);
			chk("source", 32'h1, {31'h0, current_source_en});
			ctu_far_model_inst.src(c, 1'b0);
		end
		bus(1'b1, A_LO, 8'h0C);
		ctu_far_model_inst.src(3'h3, 1'b1);
		bus(1'b0, A_LO, 8'h00);
		chk("rise", 32'h0C, rv);
		ctu_far_model_inst.src(3'h3, 1'b0);
		bus(1'b0, A_LO, 8'h00);
		chk("fall", 32'h0D, rv);
		bus(1'b1, A_LO, 8'hCD);
		ctu_far_model_inst.src(3'h2, 1'b1);
		bus(1'b0, A_LO, 8'h00);
		chk("edge2", 32'hCF, rv);
		chk("source_off", 32'h0, {31'h0, current_source_en});
		ctu_far_model_inst.src(3'h2, 1'b0);
		bus(1'b1, A_LO, 8'h0D);
		$display("edges done");
		sleep_mode <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("sleep", 32'h0, {31'h0, current_source_en});
		sleep_mode <= 1'b0;
		idle_mode <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("idle", 32'h1, {31'h0, current_source_en});
		bus(1'b1, A_HI, 8'hA8);
		chk("idlestop", 32'h0, {31'h0, current_source_en});
		idle_mode <= 1'b0;
		bus(1'b1, A_HI, 8'h8A);
		chk("disch", 32'h1, {31'h0, discharge_en});
		bus(1'b1, A_HI, 8'h88);
		chk("disch", 32'h0, {31'h0, discharge_en});
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		bus(1'b0, A_LO, 8'h00);
		chk("abandon", 32'h0, {rv[30:0], current_source_en});
		$display("power done");
		bus(1'b1, A_HI, 8'h90);
		bus(1'b1, A_LO, 8'h01);
		chk("idle_out", 32'h0, {31'h0, delay_pulse_out});
		ctu_far_model_inst.src(3'h4, 1'b1);
		chk("pulse", 32'h1, {31'h0, delay_pulse_out});
		bus(1'b0, A_LO, 8'h00);
		chk("flag1", 32'h0, rv);
		bus(1'b0, A_TR + 14'h0004, 8'h00);
		chk("status", 32'h18, rv);
		ctu_far_model_inst.src(3'h4, 1'b0);
		bus(1'b1, A_LO, 8'h01);
		chk("rearm", 32'h0, {31'h0, delay_pulse_out});
		$display("delay done");
		conclude(1'b0);
	end
endmodule // tb_top
bind ctu_edge_control ctu_chk ctu_chk_inst (.*);
